// ==== hw/cswl_top.sv ====
// control space write lock: key registers, protected regions, bus slave
//
// Overview of operation
// - five key registers, each guards one region
// - writes to a locked region are dropped
// - per-register lock key and unlock key
// - fifth key lock word locks region five
// - fifth key unlock word frees region five
// - fifth key reads lock word while locked
// - locked region five write answers bus error
// - then whole control space dead until reset
`include "cswl_defs.svh"
module cswl_top #(
  parameter int unsigned N_REGIONS = 5
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // control-space bus request
  input  wire cswl_pkg::cswl_req_t req,
  // control-space bus answer
  output cswl_pkg::cswl_rsp_t      rsp,
  // lock state per region and hang flag
  output logic [4:0]               locked,
  output logic                     space_dead
);
  localparam int unsigned WORDS = N_REGIONS * `CSWL_REGION_WORDS;

  // decode and key table are built for exactly five regions
  if (N_REGIONS != 5) begin : g_bad_regions
    $error("cswl_top: five regions required");
  end

  localparam logic [159:0] KEY_LOCK   = `CSWL_KEYS_LOCK;
  localparam logic [159:0] KEY_UNLOCK = `CSWL_KEYS_UNLOCK;

  // key index of an address, 7 when not a key register
  function automatic logic [2:0] key_idx(input logic [11:0] a);
    logic [11:0] off;
    off = a - `CSWL_KEY_BASE;
    key_idx = (off < 12'h005) ? off[2:0] : 3'h7;
  endfunction

  // region of an address, 7 when outside all regions
  function automatic logic [2:0] reg_idx(input logic [11:0] a);
    logic [11:0] off;
    off = a - `CSWL_REGION_BASE;
    reg_idx = (a >= `CSWL_REGION_BASE && 32'(off) < WORDS)
              ? off[8:6] : 3'h7;
  endfunction

  cswl_pkg::cswl_state_t st_q, st_d;
  logic [4:0]  lock_q, lock_d;
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;
  logic        rf_we;
  logic [8:0]  rf_idx;
  logic [31:0] rf_rdata;
  logic [2:0]  k, r;
  logic [11:0] roff;

  assign k    = key_idx(req.addr);
  assign r    = reg_idx(req.addr);
  assign roff = req.addr - `CSWL_REGION_BASE;
  assign rf_idx = roff[8:0];

  cswl_regfile #(.N_WORDS(WORDS)) u_rf (
    .clk   (clk),
    .rst   (rst),
    .we    (rf_we),
    .idx   (rf_idx),
    .wdata (req.wdata),
    .rdata (rf_rdata)
  );

  // ***********************************************************
  // access decode and lock state
  // ***********************************************************
  always_comb begin
    st_d    = st_q;
    lock_d  = lock_q;
    rdata_d = 32'h00000000;
    err_d   = 1'b0;
    rf_we   = 1'b0;
    unique case (st_q)
      cswl_pkg::CSWL_IDLE: begin
        if (req.valid) begin
          st_d = cswl_pkg::CSWL_RESP;
          if (req.write) begin
            if (k != 3'h7) begin
              if (req.wdata == KEY_LOCK[32*k +: 32]) begin
                lock_d[k] = 1'b1;
              end else if (req.wdata == KEY_UNLOCK[32*k +: 32]) begin
                lock_d[k] = 1'b0;
              end
            end else if (r != 3'h7) begin
              if (!lock_q[r]) begin
                rf_we = 1'b1;
              end else if (r == 3'h4) begin
                err_d = 1'b1;
                st_d  = cswl_pkg::CSWL_DEAD;
              end
              // other locked regions: write dropped
            end else begin
              err_d = 1'b1;
            end
          end else begin
            if (k != 3'h7) begin
              rdata_d = lock_q[k] ? KEY_LOCK[32*k +: 32] : `CSWL_UNLOCK_RD;
            end else if (r != 3'h7) begin
              rdata_d = rf_rdata;
            end else begin
              err_d = 1'b1;
            end
          end
        end
      end
      cswl_pkg::CSWL_RESP: begin
        st_d = cswl_pkg::CSWL_IDLE;
      end
      cswl_pkg::CSWL_DEAD: begin
        st_d = cswl_pkg::CSWL_DEAD;
      end
      default: begin
        st_d = cswl_pkg::CSWL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q    <= cswl_pkg::CSWL_IDLE;
      lock_q  <= `CSWL_LOCK_RST;
      rdata_q <= 32'h00000000;
      err_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      lock_q  <= lock_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  // ***********************************************************
  // outputs, straight from flops
  // ***********************************************************
  logic ready_q;
  logic dead_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      ready_q <= 1'b0;
      dead_q  <= 1'b0;
    end else begin
      ready_q <= (st_q == cswl_pkg::CSWL_IDLE) && req.valid;
      dead_q  <= (st_d == cswl_pkg::CSWL_DEAD);
    end
  end

  assign rsp.ready  = ready_q;
  assign rsp.err    = err_q;
  assign rsp.rdata  = rdata_q;
  assign locked     = lock_q;
  assign space_dead = dead_q;

  // ***********************************************************
  // checks
  // ***********************************************************
  sequence s_bad_write;
    st_q == cswl_pkg::CSWL_IDLE && req.valid && req.write
      && r == 3'h4 && lock_q[4] && k == 3'h7;
  endsequence

  property p_k5_lock;
    @(posedge clk) disable iff (rst)
      st_q == cswl_pkg::CSWL_IDLE && req.valid && req.write && k == 3'h4
        && req.wdata == `CSWL_K5_LOCK |=> locked[4];
  endproperty
  a_k5_lock: assert property (p_k5_lock) else $error("lock5 not set");

  property p_k5_unlock;
    @(posedge clk) disable iff (rst)
      st_q == cswl_pkg::CSWL_IDLE && req.valid && req.write && k == 3'h4
        && req.wdata == `CSWL_K5_UNLOCK |=> !locked[4];
  endproperty
  a_k5_unlock: assert property (p_k5_unlock) else $error("lock5 held");

  property p_k5_read;
    @(posedge clk) disable iff (rst)
      st_q == cswl_pkg::CSWL_IDLE && req.valid && !req.write && k == 3'h4
        && lock_q[4] |=> rsp.ready && rsp.rdata == `CSWL_K5_LOCK;
  endproperty
  a_k5_read: assert property (p_k5_read) else $error("lock5 read");

  property p_err5;
    @(posedge clk) disable iff (rst)
      s_bad_write |=> rsp.ready && rsp.err;
  endproperty
  a_err5: assert property (p_err5) else $error("no bus error");

  property p_dead;
    @(posedge clk) disable iff (rst)
      s_bad_write |=> space_dead [*8];
  endproperty
  a_dead: assert property (p_dead) else $error("space revived");

  property p_dead_quiet;
    @(posedge clk) disable iff (rst)
      space_dead |=> !rsp.ready;
  endproperty
  a_dead_quiet: assert property (p_dead_quiet) else $error("dead answered");

  property p_drop;
    @(posedge clk) disable iff (rst)
      st_q == cswl_pkg::CSWL_IDLE && req.valid && req.write
        && r != 3'h7 && lock_q[r] |-> !rf_we;
  endproperty
  a_drop: assert property (p_drop) else $error("locked write landed");

  property p_land;
    @(posedge clk) disable iff (rst)
      st_q == cswl_pkg::CSWL_IDLE && req.valid && req.write
        && r != 3'h7 && !lock_q[r] |-> rf_we ##1 rsp.ready && !rsp.err;
  endproperty
  a_land: assert property (p_land) else $error("open write lost");

  property p_other_keys;
    @(posedge clk) disable iff (rst)
      st_q == cswl_pkg::CSWL_IDLE && req.valid && req.write && k < 3'h4
        && req.wdata == KEY_UNLOCK[32*k +: 32] |=> !locked[$past(k)];
  endproperty
  a_other_keys: assert property (p_other_keys) else $error("key fail");
endmodule

// ==== hw/cswl_defs.svh ====
// constants for the control space write lock block
`ifndef CSWL_DEFS_SVH
`define CSWL_DEFS_SVH

// ***********************************************************
// address map (word addresses on the control-space bus)
// ***********************************************************
`define CSWL_ADDR_W        12
`define CSWL_KEY_BASE      12'h000
`define CSWL_KEY5_ADDR     12'h004
`define CSWL_REGION_BASE   12'h100
`define CSWL_REGION_SHIFT  6
`define CSWL_REGION_WORDS  64

// ***********************************************************
// key words
// ***********************************************************
`define CSWL_K5_LOCK       32'h143F832C
`define CSWL_K5_UNLOCK     32'h6F361E05
// key of register n+1 sits in slice n, so the list runs from key five down
`define CSWL_KEYS_LOCK     {`CSWL_K5_LOCK, 32'h1A1A0004, 32'h1A1A0003, \
                            32'h1A1A0002, 32'h1A1A0001}
`define CSWL_KEYS_UNLOCK   {`CSWL_K5_UNLOCK, 32'hC5C50004, 32'hC5C50003, \
                            32'hC5C50002, 32'hC5C50001}

// ***********************************************************
// reset values
// ***********************************************************
`define CSWL_LOCK_RST      5'h1F
`define CSWL_UNLOCK_RD     32'h00000000

`endif

// ==== hw/cswl_pkg.sv ====
// types for the control space write lock block
package cswl_pkg;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } cswl_req_t;

  typedef struct packed {
    logic        ready;
    logic        err;
    logic [31:0] rdata;
  } cswl_rsp_t;

  typedef enum logic [2:0] {
    CSWL_IDLE  = 3'b001,
    CSWL_RESP  = 3'b010,
    CSWL_DEAD  = 3'b100
  } cswl_state_t;
endpackage

// ==== hw/cswl_regfile.sv ====
// storage for the protected control registers, one flop word per entry
`include "cswl_defs.svh"
module cswl_regfile #(
  parameter int unsigned N_WORDS = 320
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // access
  input  wire logic        we,
  input  wire logic [8:0]  idx,
  input  wire logic [31:0] wdata,
  output logic      [31:0] rdata
);
  // the 9-bit index cannot reach beyond 512 words
  if (N_WORDS > 512 || N_WORDS == 0) begin : g_bad_depth
    $error("cswl_regfile: bad depth");
  end

  logic [31:0] mem_q [N_WORDS];
  logic [31:0] mem_d [N_WORDS];

  // ***********************************************************
  // write path
  // ***********************************************************
  always_comb begin
    for (int i = 0; i < N_WORDS; i++) begin
      mem_d[i] = (we && idx == 9'(i)) ? wdata : mem_q[i];
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < N_WORDS; i++) begin
      mem_q[i] <= rst ? 32'h00000000 : mem_d[i];
    end
  end

  // read path, out of range reads zero
  assign rdata = (32'(idx) < N_WORDS) ? mem_q[idx] : 32'h00000000;
endmodule

// ==== tb/cswl_init.sv ====
// bus initiator model for the control space write lock block
`include "cswl_defs.svh"
module cswl_init (
  // clock
  input  wire logic                clk,
  // control-space bus
  output cswl_pkg::cswl_req_t      req,
  input  wire cswl_pkg::cswl_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ns;

  // bus idle at time zero
  initial req = '0;

  // one word: hold until ready or for at most eight edges, then release with junk on the lines
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic e, output logic ok);
    ok = 1'b0;
    e = 1'b0;
    rd = '0;
    @(posedge clk);
    req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    // answer taken at the rising edge that samples ready high
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clk);
      if (rsp.ready === 1'b1) begin
        ok = 1'b1;
        e = rsp.err;
        rd = rsp.rdata;
      end
    end
    // release on that same edge
    req <= '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
  endtask

  // pad edit in region five: probe, unlock, edit, relock
  task automatic pad_update(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    logic        ok;
    xfer(1'b0, `CSWL_KEY5_ADDR, '0, rd, e, ok);
    if (rd === `CSWL_K5_LOCK)
      xfer(1'b1, `CSWL_KEY5_ADDR, `CSWL_K5_UNLOCK, rd, e, ok);
    xfer(1'b1, a, d, rd, e, ok);
    xfer(1'b1, `CSWL_KEY5_ADDR, `CSWL_K5_LOCK, rd, e, ok);
  endtask
endmodule

// ==== tb/tb.sv ====
// self-checking testbench for the control space write lock block
`include "cswl_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // bench signals
  // ****************
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  cswl_pkg::cswl_req_t    req;
  cswl_pkg::cswl_rsp_t    rsp;
  logic [4:0]             locked;
  logic                   space_dead;
  logic [31:0]            rd;
  logic                   e;
  logic                   ok;
  int                     errors = 0;
  int                     samples_checked = 0;
  localparam logic [11:0] K5 = `CSWL_KEY5_ADDR;

  // 10 MHz clock
  always #50 clk = ~clk;

  cswl_top #(.N_REGIONS(5)) DUT (.clk(clk), .rst(rst), .req(req),
    .rsp(rsp), .locked(locked), .space_dead(space_dead));
  cswl_init u_init (.clk(clk), .req(req), .rsp(rsp));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // access that must be answered; a hang ends the run
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    u_init.xfer(w, a, d, rd, e, ok);
    if (ok !== 1'b1) begin
      errors++;
      finish_test();
    end
  endtask

  function automatic logic [11:0] rbase(input int n);
    return `CSWL_REGION_BASE + 12'(64 * (n - 1));
  endfunction

  task automatic t_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(32'(locked), 32'h1F);
    check(32'(space_dead), 32'h0);
  endtask

  // regions one to four: drop while locked, keys, normal writes
  task automatic t_lo4();
    logic [11:0] a;
    for (int n = 1; n <= 4; n++) begin
      a = rbase(n) + 12'(n);
      acc(1'b1, a, 32'hDEAD0000);
      check(32'(e), 32'h0);
      acc(1'b0, a, '0);
      check(rd, 32'h0);
      acc(1'b1, 12'(n - 1), 32'hC5C50000 | 32'(n % 4 + 1));
      check(32'(locked), 32'h1F);
      acc(1'b1, 12'(n - 1), 32'hC5C50000 | 32'(n));
      check(32'(locked), 32'(5'h1F & ~(5'h1 << (n - 1))));
      acc(1'b1, a, 32'hA5000000 | 32'(n));
      acc(1'b0, a, '0);
      check(rd, 32'hA5000000 | 32'(n));
      acc(1'b1, 12'(n - 1), 32'h1A1A0000 | 32'(n));
      check(32'(locked), 32'h1F);
      acc(1'b1, a, 32'hFFFFFFFF);
      acc(1'b0, a, '0);
      check(rd, 32'hA5000000 | 32'(n));
    end
  endtask

  // region five: key read, unlock, edit, relock
  task automatic t_key5();
    acc(1'b0, K5, '0);
    check(rd, `CSWL_K5_LOCK);
    u_init.pad_update(12'h23F, 32'h5A5A1234);
    check(32'(locked), 32'h1F);
    acc(1'b0, 12'h23F, '0);
    check(rd, 32'h5A5A1234);
    acc(1'b1, K5, `CSWL_K5_UNLOCK);
    check(32'(locked[4]), 32'h0);
    acc(1'b0, K5, '0);
    check(rd, 32'h0);
    acc(1'b1, K5, `CSWL_K5_LOCK);
    check(32'(locked[4]), 32'h1);
    acc(1'b0, 12'h300, '0);
    check(32'(e), 32'h1);
  endtask

  // locked region five write: error, then nothing answers
  task automatic t_dead();
    u_init.xfer(1'b1, 12'h200, 32'h1, rd, e, ok);
    check(32'(ok), 32'h1);
    check(32'(e), 32'h1);
    check(32'(space_dead), 32'h1);
    u_init.xfer(1'b0, K5, '0, rd, e, ok);
    check(32'(ok), 32'h0);
    u_init.xfer(1'b1, K5, `CSWL_K5_UNLOCK, rd, e, ok);
    check(32'(ok), 32'h0);
    t_reset();
    acc(1'b0, K5, '0);
    check(rd, `CSWL_K5_LOCK);
  endtask

  // main sequence
  initial begin
    t_reset();
    t_lo4();
    t_key5();
    t_dead();
    finish_test();
  end
endmodule
